// >>> pkg/sbs_tap_map.vh
`ifndef SBS_TAP_MAP_VH
`define SBS_TAP_MAP_VH
// instruction codes, msb on the left
`define SBS_IR_W 3
`define SBS_OP_EXTEST 3'h0
`define SBS_OP_IDCODE 3'h1
`define SBS_OP_SAMPZ 3'h2
`define SBS_OP_RSV1 3'h3
`define SBS_OP_PRELOAD 3'h4
`define SBS_OP_PRIV 3'h5
`define SBS_OP_RSV2 3'h6
`define SBS_OP_BYPASS 3'h7
`define SBS_IR_CAPT 2'h1
`define SBS_ID_W 32
// arbitrary neutral identification value
`define SBS_ID_VALUE 32'h00000001
`define SBS_BSR_W 16
`define SBS_DQ_W 8
`define SBS_IN_W 8
// tap states
`define SBS_TLR 4'h0
`define SBS_RTI 4'h1
`define SBS_SELDR 4'h2
`define SBS_CAPDR 4'h3
`define SBS_SHDR 4'h4
`define SBS_EX1DR 4'h5
`define SBS_PADR 4'h6
`define SBS_EX2DR 4'h7
`define SBS_UPDR 4'h8
`define SBS_SELIR 4'h9
`define SBS_CAPIR 4'hA
`define SBS_SHIR 4'hB
`define SBS_EX1IR 4'hC
`define SBS_PAIR 4'hD
`define SBS_EX2IR 4'hE
`define SBS_UPIR 4'hF
`endif

// >>> rtl/sbs_sync2.v
`timescale 1ns/1ps
`include "sbs_tap_map.vh"
module sbs_sync2 (
  // clock and reset
  input wire mclk,
  input wire rst,
  // level in and out
  input wire asyncIn,
  output reg syncOut
);
  reg meta_q;
  always @(posedge mclk)
  begin
    if (rst)
    begin
      meta_q <= 1'b1;
      syncOut <= 1'b1;
    end
    else
    begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // sbs_sync2

// >>> rtl/sbs_tap.v
`timescale 1ns/1ps
`include "sbs_tap_map.vh"
module sbs_tap (
  // clock and reset
  input wire mclk,
  input wire rst,
  // test port pins
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdoOe,
  // memory pin levels seen by the scan ring
  input wire [`SBS_IN_W-1:0] pinIn,
  input wire [`SBS_DQ_W-1:0] dqIn,
  // functional output path of the memory
  input wire [`SBS_DQ_W-1:0] funcDq,
  input wire funcDqOe,
  input wire [1:0] funcEchoClk,
  // pin drivers
  output reg [`SBS_DQ_W-1:0] dqOut,
  output reg dqOe,
  output reg [1:0] echoClockOut
);
  wire tckS;
  wire tmsS;
  wire tdiS;
  reg tckPrev_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [`SBS_IR_W-1:0] irShift_q;
  reg [`SBS_IR_W-1:0] ir_q;
  reg [`SBS_ID_W-1:0] idShift_q;
  reg [`SBS_BSR_W-1:0] bsr_q;
  reg [`SBS_DQ_W-1:0] drive_q;
  reg bypass_q;
  reg extActive_q;
  // pins come from outside: two-stage synchronisers
  sbs_sync2 uTck (.mclk(mclk), .rst(rst), .asyncIn(tck), .syncOut(tckS));
  sbs_sync2 uTms (.mclk(mclk), .rst(rst), .asyncIn(tms), .syncOut(tmsS));
  sbs_sync2 uTdi (.mclk(mclk), .rst(rst), .asyncIn(tdi), .syncOut(tdiS));
  wire tckRise = tckS & ~tckPrev_q;
  wire tckFall = ~tckS & tckPrev_q;
  // unlisted codes 011, 101, 110 fall to bypass
  wire selBsr = (ir_q == `SBS_OP_EXTEST) | (ir_q == `SBS_OP_SAMPZ) |
    (ir_q == `SBS_OP_PRELOAD);
  wire selId = (ir_q == `SBS_OP_IDCODE);
  wire selByp = ~selBsr & ~selId;
  // dq pin levels above the input pin levels, no pinless cells
  wire [`SBS_BSR_W-1:0] ringLevels = {dqIn, pinIn};
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `SBS_TLR: state_d = tmsS ? `SBS_TLR : `SBS_RTI;
      `SBS_RTI: state_d = tmsS ? `SBS_SELDR : `SBS_RTI;
      `SBS_SELDR: state_d = tmsS ? `SBS_SELIR : `SBS_CAPDR;
      `SBS_CAPDR: state_d = tmsS ? `SBS_EX1DR : `SBS_SHDR;
      `SBS_SHDR: state_d = tmsS ? `SBS_EX1DR : `SBS_SHDR;
      `SBS_EX1DR: state_d = tmsS ? `SBS_UPDR : `SBS_PADR;
      `SBS_PADR: state_d = tmsS ? `SBS_EX2DR : `SBS_PADR;
      `SBS_EX2DR: state_d = tmsS ? `SBS_UPDR : `SBS_SHDR;
      `SBS_UPDR: state_d = tmsS ? `SBS_SELDR : `SBS_RTI;
      `SBS_SELIR: state_d = tmsS ? `SBS_TLR : `SBS_CAPIR;
      `SBS_CAPIR: state_d = tmsS ? `SBS_EX1IR : `SBS_SHIR;
      `SBS_SHIR: state_d = tmsS ? `SBS_EX1IR : `SBS_SHIR;
      `SBS_EX1IR: state_d = tmsS ? `SBS_UPIR : `SBS_PAIR;
      `SBS_PAIR: state_d = tmsS ? `SBS_EX2IR : `SBS_PAIR;
      `SBS_EX2IR: state_d = tmsS ? `SBS_UPIR : `SBS_SHIR;
      `SBS_UPIR: state_d = tmsS ? `SBS_SELDR : `SBS_RTI;
      default: state_d = `SBS_TLR;
    endcase
  end
  // rising tck: state walk, capture and shift
  always @(posedge mclk)
  begin
    if (rst)
    begin
      tckPrev_q <= 1'b1;
      state_q <= `SBS_TLR;
      irShift_q <= `SBS_OP_IDCODE;
      ir_q <= `SBS_OP_IDCODE;
      idShift_q <= {`SBS_ID_W{1'b0}};
      bsr_q <= {`SBS_BSR_W{1'b0}};
      bypass_q <= 1'b0;
    end
    else
    begin
      tckPrev_q <= tckS;
      if (tckRise)
      begin
        state_q <= state_d;
        case (state_q)
          `SBS_TLR: ir_q <= `SBS_OP_IDCODE;
          `SBS_CAPIR: irShift_q <= {ir_q[`SBS_IR_W-1], `SBS_IR_CAPT};
          `SBS_SHIR: irShift_q <= {tdiS, irShift_q[`SBS_IR_W-1:1]};
          `SBS_CAPDR:
          begin
            if (selBsr)
              bsr_q <= ringLevels;
            if (selId)
              idShift_q <= `SBS_ID_VALUE;
            bypass_q <= 1'b0;
          end
          `SBS_SHDR:
          begin
            if (selBsr)
              bsr_q <= {tdiS, bsr_q[`SBS_BSR_W-1:1]};
            if (selId)
              idShift_q <= {tdiS, idShift_q[`SBS_ID_W-1:1]};
            bypass_q <= tdiS;
          end
          default: bypass_q <= bypass_q;
        endcase
      end
      // new instruction takes effect at the update-ir fall
      if (tckFall && (state_q == `SBS_UPIR))
        ir_q <= irShift_q;
    end
  end
  // falling tck: tdo and parallel update onto drivers
  always @(posedge mclk)
  begin
    if (rst)
    begin
      tdo <= 1'b1;
      tdoOe <= 1'b0;
      drive_q <= {`SBS_DQ_W{1'b0}};
      extActive_q <= 1'b0;
    end
    else if (tckFall)
    begin
      tdoOe <= (state_q == `SBS_SHDR) | (state_q == `SBS_SHIR);
      if (state_q == `SBS_SHIR)
        tdo <= irShift_q[0];
      else if (selId)
        tdo <= idShift_q[0];
      else if (selBsr)
        tdo <= bsr_q[0];
      else
        tdo <= bypass_q;
      if (state_q == `SBS_TLR)
        extActive_q <= 1'b0;
      else if (state_q == `SBS_UPIR)
      begin
        extActive_q <= (irShift_q == `SBS_OP_EXTEST);
        drive_q <= bsr_q[`SBS_BSR_W-1:`SBS_IN_W];
      end
      else if (state_q == `SBS_UPDR && extActive_q)
        drive_q <= bsr_q[`SBS_BSR_W-1:`SBS_IN_W];
    end
  end
  // output drivers; extest overrides the functional dq path, samplez gates its enable
  always @(posedge mclk)
  begin
    if (rst)
    begin
      dqOut <= {`SBS_DQ_W{1'b0}};
      dqOe <= 1'b0;
      echoClockOut <= 2'h0;
    end
    else
    begin
      echoClockOut <= funcEchoClk;
      if (extActive_q)
      begin
        dqOut <= drive_q;
        dqOe <= 1'b1;
      end
      else
      begin
        dqOut <= funcDq;
        dqOe <= funcDqOe & (ir_q != `SBS_OP_SAMPZ);
      end
    end
  end
endmodule // sbs_tap

// >>> dv/sbs_jtag_host.sv
`timescale 1ns/1ps
module sbs_jtag_host (
  // clock
  input wire mclk,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire tdo
);
  // idle levels match the pull-ups; tck stands low between steps
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 80 ns tck period; tdo is taken just before the fall
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge mclk);
    tck <= 1'b1;
    repeat (4) @(posedge mclk);
    q = tdo;
    tck <= 1'b0;
  endtask
endmodule // sbs_jtag_host

// >>> dv/sbs_tap_chk.sv
`timescale 1ns/1ps
module sbs_tap_chk (
  // clock and reset
  input wire mclk,
  input wire rst,
  // test port
  input wire tck,
  input wire tms,
  input wire tdo,
  input wire tdoOe,
  // drivers
  input wire [1:0] funcEchoClk,
  input wire dqOe,
  input wire [1:0] echoClockOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence tdoQuiet;
    $stable(tdo) [*5];
  endsequence
  a_rst_tdo_high: assert property (disable iff (1'b0) rst |=> tdo) else $error("tdo low");
  a_rst_tdo_off: assert property (disable iff (1'b0) rst |=> !tdoOe) else $error("tdoOe");
  a_rst_dq_off: assert property (disable iff (1'b0) rst |=> !dqOe) else $error("dqOe");
  a_echo_kept: assert property (!$past(rst) |-> echoClockOut == $past(funcEchoClk))
    else $error("echo clock");
  a_tdo_rise_quiet: assert property ($rose(tck) |=> tdoQuiet) else $error("tdo moved");
  a_tdo_fall_wait: assert property ($fell(tck) |=> $stable(tdo) [*2]) else $error("tdo");
  a_shift_enter: assert property ($rose(tdoOe) |-> !tms) else $error("shift entry");
  a_shift_leave: assert property ($fell(tdoOe) |-> tms) else $error("shift exit");
endmodule // sbs_tap_chk
bind sbs_tap sbs_tap_chk chk (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdo(tdo),
  .tdoOe(tdoOe), .funcEchoClk(funcEchoClk), .dqOe(dqOe), .echoClockOut(echoClockOut));

// >>> dv/sbs_tap_test.sv
`timescale 1ns/1ps
`include "sbs_tap_map.vh"
`define SBS_CHK(nm, e, g) \
  begin \
    checksDone++; \
    if ((e) !== (g)) \
    begin \
      badCount++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module sbs_tap_test;
  logic mclk, rst, funcDqOe, q;
  logic [7:0] pinIn, dqIn, funcDq;
  logic [1:0] funcEchoClk;
  wire tck, tms, tdi, tdo, tdoOe, dqOe;
  wire [7:0] dqOut;
  wire [1:0] echoClockOut;
  int badCount, checksDone, seedVal;
  logic [31:0] got, pat;
  // the private code 101 is never loaded by this test
  logic [2:0] byCodes [4] = '{`SBS_OP_RSV1, `SBS_OP_RSV2, `SBS_OP_BYPASS, `SBS_OP_RSV1};
  sbs_tap uut (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe(tdoOe), .pinIn(pinIn), .dqIn(dqIn), .funcDq(funcDq), .funcDqOe(funcDqOe),
    .funcEchoClk(funcEchoClk), .dqOut(dqOut), .dqOe(dqOe), .echoClockOut(echoClockOut));
  sbs_jtag_host host (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    funcDq <= $urandom;
    funcDqOe <= $urandom;
    funcEchoClk <= $urandom;
  end
  task automatic stopTest;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // from run-test-idle through one ir or dr scan and back, lsb first
  task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    host.step(1'b1, 1'b0, q);
    if (ir)
      host.step(1'b1, 1'b0, q);
    host.step(1'b0, 1'b0, q);
    host.step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      host.step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    host.step(1'b1, 1'b0, q);
    host.step(1'b0, 1'b0, q);
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk);
    badCount++;
    stopTest;
  end
  initial
  begin
    {rst, pinIn, dqIn, funcDq, funcDqOe, funcEchoClk} = {1'b1, 27'h0};
    seedVal = $urandom(32'hF0BD4F35);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    host.step(1'b0, 1'b0, q);
    scan(0, 32, $urandom, got);
    `SBS_CHK("idcode", `SBS_ID_VALUE, got)
    $display("test idcode done");
    foreach (byCodes[k])
    begin
      scan(1, 3, byCodes[k], got);
      `SBS_CHK("ir capture", 2'h1, got[1:0])
      pat = $urandom;
      scan(0, 8, pat, got);
      `SBS_CHK("bypass", {pat[6:0], 1'b0}, got[7:0])
    end
    $display("test bypass done");
    pinIn <= $urandom;
    dqIn <= $urandom;
    scan(1, 3, `SBS_OP_PRELOAD, got);
    pat = $urandom;
    scan(0, 16, pat, got);
    `SBS_CHK("sample", {dqIn, pinIn}, got[15:0])
    scan(1, 3, `SBS_OP_EXTEST, got);
    `SBS_CHK("extest drive", {1'b1, pat[15:8]}, {dqOe, dqOut})
    pinIn <= $urandom;
    pat = $urandom;
    scan(0, 16, pat, got);
    `SBS_CHK("extest capture", {dqIn, pinIn}, got[15:0])
    `SBS_CHK("extest update", pat[15:8], dqOut)
    $display("test extest done");
    scan(1, 3, `SBS_OP_SAMPZ, got);
    scan(0, 16, $urandom, got);
    `SBS_CHK("samplez", {1'b0, dqIn, pinIn}, {dqOe, got[15:0]})
    $display("test samplez done");
    repeat (5) host.step(1'b1, 1'b1, q);
    host.step(1'b0, 1'b0, q);
    scan(0, 32, $urandom, got);
    `SBS_CHK("idcode after reset", `SBS_ID_VALUE, got)
    $display("test tap reset done");
    stopTest;
  end
endmodule // sbs_tap_test
